// file: design/rcb_pkg.sv
// constants, field codes and state encoding of the register test decoder
// assumes one 20 MHz core clock shared with the program-memory fetch
`default_nettype none
package rcb_pkg;

  // ----------------------------------------------------------------
  // opcode nibbles
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_SHORT = 4'h8;
  localparam logic [3:0] OP_GENERAL = 4'h9;
  localparam logic [3:0] FAM_EQ = 4'hA;
  localparam logic [3:0] FAM_MAG = 4'hB;
  localparam int FAM_SPLIT_BIT = 3;
  // supported test codes per family, one bit per third nibble
  localparam logic [15:0] EQ_CODES = 16'h50F7;
  localparam logic [15:0] MAG_CODES = 16'h3333;
  // offset value that stands for the return form
  localparam logic [7:0] OFS_RETURN = 8'h00;

  // ----------------------------------------------------------------
  // field selector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FS_P = 4'h0;
  localparam logic [3:0] FS_WP = 4'h1;
  localparam logic [3:0] FS_XS = 4'h2;
  localparam logic [3:0] FS_X = 4'h3;
  localparam logic [3:0] FS_S = 4'h4;
  localparam logic [3:0] FS_M = 4'h5;
  localparam logic [3:0] FS_B = 4'h6;
  localparam logic [3:0] FS_W = 4'h7;
  localparam logic [3:0] FS_A = 4'hF;
  localparam logic [15:0] MASK_XS = 16'h0004;
  localparam logic [15:0] MASK_X = 16'h0007;
  localparam logic [15:0] MASK_S = 16'h8000;
  localparam logic [15:0] MASK_M = 16'h7FF8;
  localparam logic [15:0] MASK_B = 16'h0003;
  localparam logic [15:0] MASK_W = 16'hFFFF;
  localparam logic [15:0] MASK_A = 16'h001F;

  // ----------------------------------------------------------------
  // timing and addressing
  // ----------------------------------------------------------------
  localparam logic [5:0] CYC_TAKEN = 6'd13;
  localparam logic [5:0] CYC_NOT_TAKEN = 6'd6;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam logic [19:0] OFS_BASE = 20'h00003;
  localparam logic [19:0] INSTR_LEN = 20'h00005;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_FAM = 7'b0000010,
    ST_CODE = 7'b0000100,
    ST_OLO = 7'b0001000,
    ST_OHI = 7'b0010000,
    ST_WAIT = 7'b0100000,
    ST_DONE = 7'b1000000
  } rcb_state_t;

endpackage
`default_nettype wire

// file: design/rcb_decoder.sv
// register compare and branch decoder: takes a test opcode nibble by
// nibble, compares fields of A, B, C, D and resolves branch or return
// assumes nibbles come from logic on core_clk, registers stay stable
// while an instruction is in flight
`default_nettype none
module rcb_decoder
  import rcb_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic nib_valid,
  input wire logic [3:0] nib_data,
  output logic nib_ready,
  input wire logic [19:0] instr_addr,
  input wire logic [63:0] reg_a,
  input wire logic [63:0] reg_b,
  input wire logic [63:0] reg_c,
  input wire logic [63:0] reg_d,
  input wire logic [3:0] ptr_p,
  output logic carry,
  output logic busy,
  output logic done,
  output logic branch_if_true,
  output logic return_if_true,
  output logic unhandled,
  output logic [19:0] next_pc
);

  // ----------------------------------------------------------------
  // field mask helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] fld_mask(input logic [3:0] fs,
                                           input logic [3:0] p);
    logic [15:0] m;
    m = 16'h0000;
    unique case (fs)
      FS_P: m = 16'h0001 << p;
      FS_WP: m = 16'hFFFF >> (4'hF - p);
      FS_XS: m = MASK_XS;
      FS_X: m = MASK_X;
      FS_S: m = MASK_S;
      FS_M: m = MASK_M;
      FS_B: m = MASK_B;
      FS_W: m = MASK_W;
      default: m = MASK_A;
    endcase
    return m;
  endfunction

  function automatic logic [5:0] nib_count(input logic [15:0] m);
    logic [5:0] n;
    n = 6'd0;
    for (int i = 0; i < 16; i++) begin
      n = n + {5'd0, m[i]};
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rcb_state_t state_q, state_d;
  logic mag_q, mag_d;
  logic [3:0] fs_q, fs_d;
  logic [3:0] code_q, code_d;
  logic [3:0] olo_q, olo_d;
  logic [7:0] ofs_q, ofs_d;
  logic [19:0] addr_q, addr_d;
  logic [5:0] cnt_q, cnt_d;
  logic [5:0] total_q, total_d;
  logic res_q, res_d;
  logic carry_q, carry_d;
  logic done_q, done_d;
  logic goto_q, goto_d;
  logic rtn_q, rtn_d;
  logic unh_q, unh_d;
  logic [19:0] npc_q, npc_d;

  // ----------------------------------------------------------------
  // comparator
  // ----------------------------------------------------------------
  logic [15:0] nmask;
  logic [63:0] wmask;
  logic [63:0] opx, opy;
  logic [63:0] xm, ym;
  logic test_true;
  logic [5:0] d_cyc;

  always_comb begin
    nmask = fld_mask(fs_q, ptr_p);
    for (int i = 0; i < 16; i++) begin
      wmask[i*4 +: 4] = {4{nmask[i]}};
    end
    d_cyc = nib_count(nmask);
  end

  always_comb begin
    // equality pairs A-B, B-C, A-C, C-D by the low code bits
    opx = (code_q[1:0] == 2'd1) ? reg_b :
          (code_q[1:0] == 2'd3) ? reg_c : reg_a;
    opy = (code_q[1:0] == 2'd0) ? reg_b :
          (code_q[1:0] == 2'd3) ? reg_d : reg_c;
    test_true = 1'b0;
    if (mag_q) begin
      // magnitude pairs: A against B, B against C
      opx = code_q[0] ? reg_b : reg_a;
      opy = code_q[0] ? reg_c : reg_b;
    end else if (code_q[3]) begin
      // zero tests: A or C against zero, other codes refused
      opx = code_q[1] ? reg_c : reg_a;
      opy = 64'h0;
    end
    xm = opx & wmask;
    ym = opy & wmask;
    if (mag_q) begin
      unique case (code_q[3:2])
        2'd0: test_true = xm > ym;
        2'd1: test_true = xm < ym;
        2'd2: test_true = xm >= ym;
        2'd3: test_true = xm <= ym;
      endcase
    end else begin
      // equal family: code bit 2 selects unequal
      unique case (code_q[3:2])
        2'd0: test_true = xm == ym;
        2'd1: test_true = xm != ym;
        2'd2: test_true = xm == ym;
        2'd3: test_true = xm != ym;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic take;
  logic [15:0] legal;

  always_comb begin
    nib_ready = state_q == ST_IDLE || state_q == ST_FAM ||
                state_q == ST_CODE || state_q == ST_OLO ||
                state_q == ST_OHI;
    take = nib_ready && nib_valid;
    legal = mag_q ? MAG_CODES : EQ_CODES;
    state_d = state_q;
    mag_d = mag_q;
    fs_d = fs_q;
    code_d = code_q;
    olo_d = olo_q;
    ofs_d = ofs_q;
    addr_d = addr_q;
    total_d = total_q;
    res_d = res_q;
    carry_d = carry_q;
    npc_d = npc_q;
    done_d = 1'b0;
    goto_d = 1'b0;
    rtn_d = 1'b0;
    unh_d = 1'b0;
    // elapsed cycles since the first nibble, counting on through stalls and saturating at CNT_MAX
    cnt_d = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 6'd1;
    unique case (state_q)
      ST_IDLE: begin
        cnt_d = 6'd0;
        if (take) begin
          cnt_d = 6'd1;
          addr_d = instr_addr;
          if (nib_data == OP_SHORT) begin
            fs_d = FS_A;
            state_d = ST_FAM;
          end else if (nib_data == OP_GENERAL) begin
            fs_d = FS_W;
            state_d = ST_FAM;
          end else begin
            unh_d = 1'b1;
            done_d = 1'b1;
            state_d = ST_DONE;
          end
        end
      end
      ST_FAM: begin
        if (take) begin
          state_d = ST_CODE;
          if (fs_q == FS_A) begin
            mag_d = nib_data == FAM_MAG;
            if (nib_data != FAM_EQ && nib_data != FAM_MAG) begin
              unh_d = 1'b1;
              done_d = 1'b1;
              state_d = ST_DONE;
            end
          end else begin
            // field in low bits, family in the top bit
            mag_d = nib_data[FAM_SPLIT_BIT];
            fs_d = {1'b0, nib_data[2:0]};
          end
        end
      end
      ST_CODE: begin
        if (take) begin
          code_d = nib_data;
          state_d = ST_OLO;
          if (!legal[nib_data]) begin
            unh_d = 1'b1;
            done_d = 1'b1;
            state_d = ST_DONE;
          end
        end
      end
      ST_OLO: begin
        if (take) begin
          olo_d = nib_data;
          state_d = ST_OHI;
        end
      end
      ST_OHI: begin
        if (take) begin
          ofs_d = {nib_data, olo_q};
          res_d = test_true;
          total_d = (test_true ? CYC_TAKEN : CYC_NOT_TAKEN) + d_cyc;
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // done stands in the last cycle of the instruction
        if (cnt_q >= total_q - 6'd2) begin
          state_d = ST_DONE;
          done_d = 1'b1;
          carry_d = res_q;
          npc_d = addr_q + INSTR_LEN;
          if (res_q) begin
            if (ofs_q == OFS_RETURN) begin
              rtn_d = 1'b1;
            end else begin
              goto_d = 1'b1;
              npc_d = addr_q + OFS_BASE + {{12{ofs_q[7]}}, ofs_q};
            end
          end
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
        cnt_d = 6'd0;
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 6'd0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      mag_q <= 1'b0;
      fs_q <= FS_A;
      code_q <= 4'h0;
      olo_q <= 4'h0;
      ofs_q <= 8'h00;
      addr_q <= 20'h00000;
      cnt_q <= 6'd0;
      total_q <= CYC_NOT_TAKEN;
      res_q <= 1'b0;
      carry_q <= 1'b0;
      done_q <= 1'b0;
      goto_q <= 1'b0;
      rtn_q <= 1'b0;
      unh_q <= 1'b0;
      npc_q <= 20'h00000;
    end else if (clk_en) begin
      state_q <= state_d;
      mag_q <= mag_d;
      fs_q <= fs_d;
      code_q <= code_d;
      olo_q <= olo_d;
      ofs_q <= ofs_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      total_q <= total_d;
      res_q <= res_d;
      carry_q <= carry_d;
      done_q <= done_d;
      goto_q <= goto_d;
      rtn_q <= rtn_d;
      unh_q <= unh_d;
      npc_q <= npc_d;
    end
  end

  assign carry = carry_q;
  assign busy = state_q != ST_IDLE;
  assign done = done_q;
  assign branch_if_true = goto_q;
  assign return_if_true = rtn_q;
  assign unhandled = unh_q;
  assign next_pc = npc_q;

endmodule
`default_nettype wire

// file: bench/rcb_decoder_props.sv
// port checker for the register test decoder
// assumes binding from the bench top, one core clock
`default_nettype none
module rcb_decoder_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic nib_valid,
  input wire logic nib_ready,
  input wire logic carry,
  input wire logic busy,
  input wire logic done,
  input wire logic branch_if_true,
  input wire logic return_if_true,
  input wire logic unhandled,
  input wire logic [19:0] next_pc
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // cycles since first nibble
  // ------------------------------------------------------------
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (clk_en && nib_valid && nib_ready && !busy) begin
      cnt_d = 6'h01;
    end else if (clk_en && cnt_q != 6'h3F) begin
      cnt_d = cnt_q + 6'h01;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  done_pulse_a: assert property (done |=> !done)
    else $error("done held too long");
  flag_done_a: assert property (
    (branch_if_true || return_if_true || unhandled) |-> done)
    else $error("result flag without done");
  one_result_a: assert property (
    done |-> $onehot0({branch_if_true, return_if_true, unhandled}))
    else $error("two result flags");
  carry_hold_a: assert property (!done |-> $stable(carry))
    else $error("carry moved outside done");
  pc_hold_a: assert property (!done |-> $stable(next_pc))
    else $error("next pc moved outside done");
  unh_carry_a: assert property (unhandled |-> $stable(carry))
    else $error("unhandled changed carry");
  min_time_a: assert property (
    (done && !unhandled) |-> cnt_q >= 6'd6)
    else $error("test finished too early");
  taken_time_a: assert property (
    (branch_if_true || return_if_true) |-> cnt_q >= 6'd13)
    else $error("taken test finished too early");
  idle_after_a: assert property (done |=> !busy && nib_ready)
    else $error("not idle after done");
endmodule
`default_nettype wire

// file: bench/rcb_prog_mem.sv
// program memory model handing opcode nibbles one by one
// assumes the bench pushes nibbles away from the rising edge
`default_nettype none
module rcb_prog_mem (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic nib_ready,
  input wire logic stall_en,
  output logic nib_valid,
  output logic [3:0] nib_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] q[$];
  logic [7:0] gap_q = 8'h5A;
  task automatic push(input logic [3:0] n);
    q.push_back(n);
  endtask
  initial begin
    nib_valid = 1'b0;
    nib_data = 4'hF;
  end
  // offer held until taken; idle data toggles so stale values never match
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nib_valid <= 1'b0;
    end else if (!nib_valid || nib_ready) begin
      if (nib_valid) q.pop_front();
      gap_q <= {gap_q[6:0], gap_q[7] ^ gap_q[5]};
      if (q.size() != 0 && !(stall_en && gap_q[0])) begin
        nib_valid <= 1'b1;
        nib_data <= q[0];
      end else begin
        nib_valid <= 1'b0;
        nib_data <= ~nib_data;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/rcb_decoder_tb.sv
// self-checking bench for the register test decoder
// assumes the memory model feeds nibbles, clock enable held high
`default_nettype none
module rcb_decoder_tb;
  import rcb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, reset_n = 0, clk_en = 1, stall_en = 0, exp_c = 0;
  logic nib_valid, nib_ready, carry, busy, done, br, ret, unh;
  logic [3:0] nib_data, ptr_p = 0;
  logic [19:0] instr_addr = 0, next_pc;
  logic [63:0] ra = 0, rb = 0, rc = 0, rd = 0;
  logic [15:0] lf = 16'h982C;
  logic [15:0] fmask [8] = '{16'h0000, 16'h0000, MASK_XS, MASK_X, MASK_S,
                             MASK_M, MASK_B, MASK_W};
  int errors = 0, num_checks = 0;
  always #25 core_clk = ~core_clk;
  rcb_decoder dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .nib_valid(nib_valid), .nib_data(nib_data), .nib_ready(nib_ready),
    .instr_addr(instr_addr), .reg_a(ra), .reg_b(rb), .reg_c(rc),
    .reg_d(rd), .ptr_p(ptr_p), .carry(carry), .busy(busy), .done(done),
    .branch_if_true(br), .return_if_true(ret), .unhandled(unh),
    .next_pc(next_pc));
  rcb_prog_mem mem (.core_clk(core_clk), .reset_n(reset_n),
    .nib_ready(nib_ready), .stall_en(stall_en), .nib_valid(nib_valid),
    .nib_data(nib_data));
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(input bit ok, input string what);
    num_checks++;
    if (!ok) begin
      errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // one instruction: hd holds the first three nibbles, k are sent
  // ------------------------------------------------------------
  task automatic run(input logic [11:0] hd, input int k);
    logic [63:0] a, b, c, d, m, x, y;
    logic [19:0] pa, w;
    logic [15:0] r, nm, o;
    logic [3:0] f, cd;
    logic mag, t;
    int cyc, first, last, want, n;
    r = rnd();
    o = rnd();
    if (o[2:0] == 3'h0) o = 16'h0000; // return form
    pa = {rnd(), 4'h0} ^ 20'(rnd());
    a = {4{rnd()}};
    b = r[0] ? a : {4{rnd()}};
    c = r[1] ? b : {4{rnd()}};
    d = r[2] ? c : {4{rnd()}};
    if (r[3]) a = 64'h0;
    mag = (hd[11:8] == OP_SHORT) ? hd[4] : hd[7];
    f = (hd[11:8] == OP_SHORT) ? FS_A : {1'b0, hd[6:4]};
    cd = hd[3:0];
    nm = (f == FS_A) ? MASK_A : fmask[f[2:0]];
    if (f == FS_P) nm = 16'h0001 << r[15:12];
    if (f == FS_WP) nm = (16'h0002 << r[15:12]) - 16'h0001;
    n = $countones(nm);
    for (int i = 0; i < 16; i++) m[4 * i +: 4] = {4{nm[i]}};
    x = (cd[1:0] == 2'd1) ? b : (cd[1:0] == 2'd3) ? c : a;
    y = (cd[1:0] == 2'd0) ? b : (cd[1:0] == 2'd3) ? d : c;
    if (mag) begin
      x = (cd[0] ? b : a) & m;
      y = (cd[0] ? c : b) & m;
      case (cd[3:2])
        2'd0: t = x > y;
        2'd1: t = x < y;
        2'd2: t = x >= y;
        default: t = x <= y;
      endcase
    end else if (cd[3]) begin
      t = ((cd[1] ? c : a) & m) != 64'h0;
    end else begin
      t = cd[2] ? (x & m) != (y & m) : (x & m) == (y & m);
    end
    @(posedge core_clk);
    {ra, rb, rc, rd} <= {a, b, c, d};
    ptr_p <= r[15:12];
    instr_addr <= pa;
    stall_en <= r[5];
    @(negedge core_clk);
    w = {hd, o[3:0], o[7:4]};
    for (int i = 0; i < k; i++) mem.push(w[19 - 4 * i -: 4]);
    first = -1;
    last = 0;
    cyc = 0;
    while (done !== 1'b1 && cyc < 200) begin
      @(posedge core_clk);
      if (nib_valid === 1'b1 && nib_ready === 1'b1) begin
        if (first < 0) first = cyc;
        last = cyc;
      end
      cyc++;
      #1;
    end
    chk(done === 1'b1, "no done");
    if (done !== 1'b1) summarize();
    want = (t ? 13 : 6) + n - 1 + first;
    if (k < 5) want = last + 1;
    else if (last + 2 > want) want = last + 2;
    if (k == 5) exp_c = t;
    chk(cyc == want, "cycle count");
    chk(carry === exp_c, "carry");
    chk(unh === (k < 5), "unhandled");
    chk(br === (k == 5 && t && o[7:0] != OFS_RETURN), "branch");
    chk(ret === (k == 5 && t && o[7:0] == OFS_RETURN), "return");
    if (k == 5) chk(next_pc === ((t && o[7:0] != OFS_RETURN) ?
      pa + 20'h3 + {{12{o[7]}}, o[7:0]} : pa + 20'h5), "pc");
  endtask
  // ------------------------------------------------------------
  // every code of both families, short form and each field
  // ------------------------------------------------------------
  initial begin
    logic sup;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      for (int cc = 0; cc < 16; cc++) begin
        sup = s ? MAG_CODES[cc] : EQ_CODES[cc];
        run({OP_SHORT, s ? FAM_MAG : FAM_EQ, 4'(cc)}, sup ? 5 : 3);
        for (int fi = 0; fi < 8; fi++)
          run({OP_GENERAL, 1'(s), 3'(fi), 4'(cc)}, sup ? 5 : 3);
      end
      $display("family %0d codes done", s);
    end
    run({4'h3, 8'h00}, 1);
    run({OP_SHORT, 4'h7, 4'h0}, 2);
    $display("refused openings done");
    summarize();
  end
endmodule
bind rcb_decoder rcb_decoder_props props_i (.core_clk(core_clk),
  .reset_n(reset_n), .clk_en(clk_en), .nib_valid(nib_valid),
  .nib_ready(nib_ready), .carry(carry), .busy(busy), .done(done),
  .branch_if_true(branch_if_true), .return_if_true(return_if_true),
  .unhandled(unhandled), .next_pc(next_pc));
`default_nettype wire
